// File: sample_timestamp_counter.sv
// sample timestamp counter with its axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none

module sample_timestamp_counter #(
	parameter int CNT_W = 64 // counter width
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [19:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [19:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// clock logic, same clock domain
	input  wire logic        base_sample_tick,
	input  wire logic        clock_gen_active,
	input  wire logic        card_start,
	input  wire logic        gated_mode,
	input  wire logic [31:0] effective_sample_rate,
	input  wire logic [31:0] oversampling_factor,
	// trigger and gate pins, asynchronous
	input  wire logic        trigger_pin,
	input  wire logic        gate_pin,
	// stamp hand-off to the stamp store
	output logic [63:0]      stamp_data,
	output logic             stamp_strobe
);

	////////////////////////////////////////////////////////////////////////
	// address decode helper
	function automatic logic hit(input logic [19:0] a,
	                             input logic [17:0] idx);
		hit = (a[19:2] == idx);
	endfunction

	// byte-lane merge helper
	function automatic logic [31:0] merge(input logic [31:0] old_v,
	                                      input logic [31:0] new_v,
	                                      input logic [3:0]  be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state
	logic [19:0]      awaddr_q, awaddr_d;     // held write address
	logic             aw_held_q, aw_held_d;   // address taken
	logic [31:0]      wdata_q, wdata_d;       // held write data
	logic [3:0]       wstrb_q, wstrb_d;       // held byte enables
	logic             w_held_q, w_held_d;     // data taken
	logic             awready_q, awready_d;
	logic             wready_q, wready_d;
	logic             bvalid_q, bvalid_d;
	logic [1:0]       bresp_q, bresp_d;
	logic             arready_q, arready_d;
	logic             rvalid_q, rvalid_d;
	logic [31:0]      rdata_q, rdata_d;
	logic [1:0]       rresp_q, rresp_d;
	logic [31:0]      cmd_q, cmd_d;           // stored mode and source
	logic             zero_q, zero_d;         // pending zero command
	logic [CNT_W-1:0] cnt_q, cnt_d;           // timestamp counter
	logic [63:0]      stamp_q, stamp_d;       // last captured stamp
	logic             valid_q, valid_d;       // unread stamp flag
	logic             strobe_q, strobe_d;     // one-cycle capture pulse
	logic [2:0]       trig_q, trig_d;         // sync pair plus history
	logic [2:0]       gate_q, gate_d;         // sync pair plus history

	// decoded controls
	logic             mode_explicit;
	logic             mode_on_start;
	logic             src_full;
	logic             enabled;
	logic             trig_edge;
	logic             gate_edge;
	logic             capture;

	////////////////////////////////////////////////////////////////////////
	// command decode; software builds the word from one of each field
	always_comb begin
		// any other mode code, 6h included, leaves the block disabled
		mode_explicit = (cmd_q & stamp_pkg::MODE_MASK)
		                == stamp_pkg::MODE_EXPLICIT;
		mode_on_start = (cmd_q & stamp_pkg::MODE_MASK)
		                == stamp_pkg::MODE_ON_START;
		// split sources are not built, so they simply hold the count
		src_full      = (cmd_q & stamp_pkg::SRC_MASK)
		                == stamp_pkg::SRC_FULL;
		enabled       = mode_explicit | mode_on_start;
		// only the second and third stages are looked at
		trig_edge     = trig_q[1] & ~trig_q[2];
		gate_edge     = gate_q[1] ^ gate_q[2];
		// gate start and end both stamped in gated sampling
		capture       = enabled & (gated_mode ? gate_edge
		                                      : trig_edge);
	end


	////////////////////////////////////////////////////////////////////////
	// bus next-state: write and read channels
	always_comb begin
		logic wr_do;
		logic rd_do;
		logic [31:0] merged;
		wr_do     = 1'b0;
		rd_do     = 1'b0;
		merged    = 32'h0000_0000;
		awaddr_d  = awaddr_q;
		aw_held_d = aw_held_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		w_held_d  = w_held_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		cmd_d     = cmd_q;
		zero_d    = 1'b0;
		valid_d   = valid_q;
		// address and data taken in either order
		if (s_axi_awvalid && awready_q) begin
			awaddr_d  = s_axi_awaddr;
			aw_held_d = 1'b1;
		end
		if (s_axi_wvalid && wready_q) begin
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
			w_held_d = 1'b1;
		end
		// response retires before the next write is accepted
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		// execute once both halves are held
		if (aw_held_q && w_held_q && !bvalid_q) begin
			wr_do     = 1'b1;
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = stamp_pkg::RESP_SLVERR; // unmapped or read-only
			if (hit(awaddr_q, stamp_pkg::IDX_CMD)) begin
				bresp_d = stamp_pkg::RESP_OKAY;
				merged  = merge(cmd_q, wdata_q, wstrb_q);
				cmd_d   = merged & stamp_pkg::CMD_STORE;
				// zero only while clock generation runs
				zero_d  = ((merged & stamp_pkg::CMD_ZERO) != 32'h0000_0000)
				          & wstrb_q[0] & clock_gen_active;
			end
		end
		// read channel: one outstanding read
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && arready_q) begin
			rd_do    = 1'b1;
			rvalid_d = 1'b1;
			rresp_d  = stamp_pkg::RESP_OKAY;
			rdata_d  = 32'h0000_0000;
			if (hit(s_axi_araddr, stamp_pkg::IDX_CMD)) begin
				rdata_d = cmd_q;
			end else if (hit(s_axi_araddr, stamp_pkg::IDX_RATE)) begin
				rdata_d = effective_sample_rate;
			end else if (hit(s_axi_araddr, stamp_pkg::IDX_OVS)) begin
				// clock logic drives 0 while oversampling is off; read back as 1
				rdata_d = (oversampling_factor == 32'h0000_0000)
				          ? 32'h0000_0001 : oversampling_factor;
			end else if (hit(s_axi_araddr, stamp_pkg::IDX_STAMP_LO)) begin
				rdata_d = stamp_q[31:0];
			end else if (hit(s_axi_araddr, stamp_pkg::IDX_STAMP_HI)) begin
				rdata_d = stamp_q[63:32];
				valid_d = 1'b0; // reading the high word consumes it
			end else if (hit(s_axi_araddr, stamp_pkg::IDX_STATUS)) begin
				rdata_d[stamp_pkg::ST_VALID]      = valid_q;
				rdata_d[stamp_pkg::ST_CLK_ACTIVE] = clock_gen_active;
				rdata_d[stamp_pkg::ST_COUNTING]   = enabled & src_full;
			end else begin
				rresp_d = stamp_pkg::RESP_SLVERR;
			end
		end
		// a new capture wins over the consuming read
		if (capture) begin
			valid_d = 1'b1;
		end
		// readies registered so outputs come from flops
		awready_d = !aw_held_d && !(wr_do || bvalid_d);
		wready_d  = !w_held_d && !(wr_do || bvalid_d);
		arready_d = !rvalid_d && !rd_do;
	end

	////////////////////////////////////////////////////////////////////////
	// counter and capture next-state
	always_comb begin
		cnt_d    = cnt_q;
		stamp_d  = stamp_q;
		strobe_d = 1'b0;
		trig_d   = {trig_q[1:0], trigger_pin};
		gate_d   = {gate_q[1:0], gate_pin};
		if (!enabled) begin
			// disabled mode keeps the counter cleared
			cnt_d = '0;
		end else if (zero_q) begin
			cnt_d = '0;
		end else if (mode_on_start && card_start) begin
			cnt_d = '0;
		end else if (src_full && base_sample_tick) begin
			// tick is the base converter rate, never the interlaced
			// doubled rate; oversampled rate is what the tick carries
			cnt_d = cnt_q + 1'b1;
		end
		if (capture) begin
			stamp_d  = 64'(cnt_q);
			strobe_d = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers, synchronous active-low reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_q  <= 20'h00000;
			aw_held_q <= 1'b0;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			w_held_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= 2'h0;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= 2'h0;
			cmd_q     <= stamp_pkg::CMD_RESET;
			zero_q    <= 1'b0;
			cnt_q     <= '0;
			stamp_q   <= 64'h0000_0000_0000_0000;
			valid_q   <= 1'b0;
			strobe_q  <= 1'b0;
			trig_q    <= 3'h0;
			gate_q    <= 3'h0;
		end else begin
			awaddr_q  <= awaddr_d;
			aw_held_q <= aw_held_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			w_held_q  <= w_held_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
			cmd_q     <= cmd_d;
			zero_q    <= zero_d;
			cnt_q     <= cnt_d;
			stamp_q   <= stamp_d;
			valid_q   <= valid_d;
			strobe_q  <= strobe_d;
			trig_q    <= trig_d;
			gate_q    <= gate_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign stamp_data    = stamp_q;
	assign stamp_strobe  = strobe_q;

endmodule

`default_nettype wire

// File: stamp_pkg.sv
// constants, register map and field layout of the sample timestamp counter
// Overview of operation
// - count at non-interlaced rate, max 125 MS/s
// - interlaced: clocked by base sample clock only
// - every captured stamp is 64 bits wide
// - count at internally used sampling rate
// - read-only register reports internal sample rate
// - read-only oversampling factor, 1 when inactive
// - zero command code clears the counter
// - standard mode counts ignoring acquisition start/stop
// - mode 2h standard, mode 0 disables
// - mode 4h clears counter at card start
// - source 100h: full width on sample clock
// - trigger stores count; gate stores start and end
// - zero command needs active clock generation
package stamp_pkg;

	////////////////////////////////////////////////////////////////////////
	// bus geometry
	localparam int          ADDR_W        = 20;    // byte address width
	localparam int          DATA_W        = 32;    // register word width
	localparam int          STAMP_W       = 64;    // captured stamp width

	////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [17:0] IDX_CMD       = 18'h0B798; // timestamp_command
	localparam logic [17:0] IDX_RATE      = 18'h04E20; // effective_sample_rate
	localparam logic [17:0] IDX_OVS       = 18'h30DBB; // oversampling_factor
	localparam logic [17:0] IDX_STAMP_LO  = 18'h00000; // captured stamp low
	localparam logic [17:0] IDX_STAMP_HI  = 18'h00001; // captured stamp high
	localparam logic [17:0] IDX_STATUS    = 18'h00002; // block status

	////////////////////////////////////////////////////////////////////////
	// command word fields
	localparam logic [31:0] CMD_ZERO      = 32'h0000_0001; // counter_zero_cmd
	localparam logic [31:0] MODE_OFF      = 32'h0000_0000; // stamp_off_code
	localparam logic [31:0] MODE_EXPLICIT = 32'h0000_0002; // explicit_zero_mode
	localparam logic [31:0] MODE_ON_START = 32'h0000_0004; // zero_on_start_mode
	localparam logic [31:0] MODE_MASK     = 32'h0000_0006; // mode field
	localparam logic [31:0] SRC_FULL      = 32'h0000_0100; // full_width_sample_clocked
	localparam logic [31:0] SRC_MASK      = 32'h0000_0700; // counter source field
	localparam logic [31:0] FEAT_NONE     = 32'h0000_0000; // no_extra_stamps
	localparam logic [31:0] CMD_STORE     = 32'h0000_0706; // bits kept in the register
	localparam logic [31:0] CMD_RESET     = 32'h0000_0000; // reset value: disabled

	////////////////////////////////////////////////////////////////////////
	// status word bits
	localparam int          ST_VALID      = 0;     // unread stamp present
	localparam int          ST_CLK_ACTIVE = 1;     // clock generation running
	localparam int          ST_COUNTING   = 2;     // counter enabled on the full-width source

	////////////////////////////////////////////////////////////////////////
	// axi responses
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// File: sample_timestamp_counter_checker.sv
// port assertions for the sample timestamp counter
`timescale 1ns/1ps
`default_nettype none
module sample_timestamp_counter_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [19:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [19:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] effective_sample_rate,
	input wire logic [31:0] oversampling_factor,
	input wire logic [63:0] stamp_data,
	input wire logic        stamp_strobe
);
	////////////////////////////////////////////////////////////////////////
	// byte addresses of the read-only parameters
	localparam logic [19:0] RATE_A = {stamp_pkg::IDX_RATE, 2'b00};
	localparam logic [19:0] OVS_A  = {stamp_pkg::IDX_OVS, 2'b00};
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// channel handshakes
	logic aw_t, w_t, ar_t;
	assign aw_t = s_axi_awvalid && s_axi_awready;
	assign w_t  = s_axi_wvalid && s_axi_wready;
	assign ar_t = s_axi_arvalid && s_axi_arready;
	////////////////////////////////////////////////////////////////////////
	a_write_answer: assert property (aw_t && w_t |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (ar_t |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_rate_report: assert property (ar_t && s_axi_araddr == RATE_A
		|=> s_axi_rdata == $past(effective_sample_rate))
		else $error("rate readback wrong");
	a_ro_refused: assert property (aw_t && w_t && s_axi_awaddr == RATE_A
		|-> ##2 s_axi_bresp == stamp_pkg::RESP_SLVERR)
		else $error("read-only write accepted");
	a_ovs_unity: assert property (ar_t && s_axi_araddr == OVS_A
		&& oversampling_factor == 32'h0 |=> s_axi_rdata == 32'h1)
		else $error("idle oversampling not one");
	a_ovs_pass: assert property (ar_t && s_axi_araddr == OVS_A
		&& oversampling_factor != 32'h0
		|=> s_axi_rdata == $past(oversampling_factor))
		else $error("oversampling readback wrong");
	a_stamp_steady: assert property ($changed(stamp_data) |-> stamp_strobe)
		else $error("stamp changed without strobe");
	// main scenarios reached
	cover property (stamp_strobe);
	cover property (ar_t && s_axi_araddr == OVS_A);
	cover property (s_axi_bvalid && s_axi_bresp == stamp_pkg::RESP_SLVERR);
endmodule
bind sample_timestamp_counter sample_timestamp_counter_checker i_chk (.*);
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the sample timestamp counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// design inputs, named as the ports
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, base_sample_tick, card_start;
	logic        clock_gen_active, gated_mode, trigger_pin, gate_pin;
	logic [19:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, effective_sample_rate, oversampling_factor;
	logic [3:0]  s_axi_wstrb;
	// design outputs
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, stamp_strobe;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [63:0] stamp_data;
	// expectation queues and bookkeeping
	logic [63:0] exp_s[$];
	logic [33:0] exp_r[$];
	logic [1:0]  exp_b[$];
	logic [63:0] cnt;
	int          bad_count, num_checks, cyc, n;
	sample_timestamp_counter i_sample_timestamp_counter (.*);
	////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// monitor: a result with no note pending compares against unknown
	always @(posedge aclk) begin
		cyc++;
		if (stamp_strobe)
			chk(stamp_data, exp_s.size() ? exp_s.pop_front() : 'x);
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, exp_r.size() ? exp_r.pop_front() : 'x);
		if (s_axi_bvalid && s_axi_bready)
			chk(s_axi_bresp, exp_b.size() ? exp_b.pop_front() : 'x);
		if (cyc == 4000) begin
			bad_count++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////
	// bus master: address and data offered together, held until taken
	task automatic wr(input logic [17:0] idx, input logic [31:0] d,
	                  input logic [1:0] r);
		@(posedge aclk);
		exp_b.push_back(r);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [17:0] idx, input logic [33:0] e);
		@(posedge aclk);
		exp_r.push_back(e);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
	// k sample ticks, one per cycle back to back
	task automatic ticks(input int k);
		repeat (k) begin
			@(posedge aclk);
			base_sample_tick <= 1'b1;
		end
		@(posedge aclk);
		base_sample_tick <= 1'b0;
		cnt += k;
	endtask
	// one trigger rise, or one gate toggle; counter idle meanwhile
	task automatic hit(input bit g, input bit want);
		@(posedge aclk);
		if (want) exp_s.push_back(cnt);
		if (g) gate_pin <= ~gate_pin;
		else trigger_pin <= 1'b1;
		repeat (6) @(posedge aclk);
		trigger_pin <= 1'b0;
		repeat (6) @(posedge aclk);
	endtask
	task automatic start_pulse;
		@(posedge aclk);
		card_start <= 1'b1;
		@(posedge aclk);
		card_start <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, base_sample_tick, card_start} = '0;
		{clock_gen_active, gated_mode, trigger_pin, gate_pin} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		oversampling_factor = 32'h0;
		s_axi_wstrb = 4'hF;
		{bad_count, num_checks, cyc} = '0;
		void'($urandom(32'h8a38e567));
		effective_sample_rate = $urandom;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values, parameters, refusals
		rd(stamp_pkg::IDX_CMD, {stamp_pkg::RESP_OKAY, stamp_pkg::CMD_RESET});
		rd(stamp_pkg::IDX_RATE, {stamp_pkg::RESP_OKAY, effective_sample_rate});
		rd(stamp_pkg::IDX_OVS, {stamp_pkg::RESP_OKAY, 32'h1});
		n = $urandom_range(2, 16);
		oversampling_factor <= n;
		rd(stamp_pkg::IDX_OVS, {stamp_pkg::RESP_OKAY, 32'(n)});
		wr(stamp_pkg::IDX_RATE, 32'h1, stamp_pkg::RESP_SLVERR);
		rd(18'h00100, {stamp_pkg::RESP_SLVERR, 32'h0});
		// standard mode: card start must not disturb the count
		clock_gen_active <= 1'b1;
		cnt = '0;
		wr(stamp_pkg::IDX_CMD, stamp_pkg::MODE_EXPLICIT | stamp_pkg::SRC_FULL
			| stamp_pkg::FEAT_NONE, stamp_pkg::RESP_OKAY);
		rd(stamp_pkg::IDX_CMD, {stamp_pkg::RESP_OKAY, stamp_pkg::MODE_EXPLICIT
			| stamp_pkg::SRC_FULL});
		ticks($urandom_range(1, 40));
		start_pulse();
		ticks($urandom_range(1, 40));
		hit(1'b0, 1'b1);
		// zero ignored while clock generation is idle
		clock_gen_active <= 1'b0;
		wr(stamp_pkg::IDX_CMD, 32'h103, stamp_pkg::RESP_OKAY);
		hit(1'b0, 1'b1);
		// status: unread stamp, clock generation idle, counting
		rd(stamp_pkg::IDX_STATUS, {stamp_pkg::RESP_OKAY, 32'h0000_0005});
		rd(stamp_pkg::IDX_STAMP_LO, {stamp_pkg::RESP_OKAY, cnt[31:0]});
		rd(stamp_pkg::IDX_STAMP_HI, {stamp_pkg::RESP_OKAY, cnt[63:32]});
		// high word read consumes the stamp
		rd(stamp_pkg::IDX_STATUS, {stamp_pkg::RESP_OKAY, 32'h0000_0004});
		clock_gen_active <= 1'b1;
		wr(stamp_pkg::IDX_CMD, 32'h103, stamp_pkg::RESP_OKAY);
		cnt = '0;
		ticks($urandom_range(1, 40));
		hit(1'b0, 1'b1);
		// start-reset mode, then gate edges
		wr(stamp_pkg::IDX_CMD, stamp_pkg::MODE_ON_START | stamp_pkg::SRC_FULL,
			stamp_pkg::RESP_OKAY);
		ticks(7);
		start_pulse();
		cnt = '0;
		ticks($urandom_range(1, 40));
		hit(1'b0, 1'b1);
		gated_mode <= 1'b1;
		hit(1'b1, 1'b1);
		ticks($urandom_range(1, 40));
		hit(1'b1, 1'b1);
		gated_mode <= 1'b0;
		// split counter source absent: count holds, stamps still taken
		wr(stamp_pkg::IDX_CMD, stamp_pkg::MODE_ON_START | 32'h0000_0200,
			stamp_pkg::RESP_OKAY);
		ticks(5);
		cnt -= 5;
		hit(1'b0, 1'b1);
		// disabled: no stamps at all
		wr(stamp_pkg::IDX_CMD, stamp_pkg::MODE_OFF | stamp_pkg::SRC_FULL,
			stamp_pkg::RESP_OKAY);
		ticks(5);
		hit(1'b0, 1'b0);
		repeat (10) @(posedge aclk);
		chk(exp_s.size() + exp_r.size() + exp_b.size(), 64'h0);
		summarize();
	end
endmodule
`default_nettype wire
